// ==== pkg/match_cam_pkg.sv ====
package match_cam_pkg;

    // Array shape
    localparam int ROWS       = 8;
    localparam int SHORT_ROWS = 6;
    localparam int SHORT_W    = 17;
    localparam int FULL_W     = 32;
    localparam int STATE_W    = 3;
    localparam int GROUP_W    = 6;

    // Register port field positions, bit 0 is the most significant (big-endian numbering)
    localparam int SHORT_A_MSB   = 0;
    localparam int SHORT_A_ST    = 18;
    localparam int SHORT_B_MSB   = 21;
    localparam int SHORT_B_ST    = 39;
    localparam int FULL_V_MSB    = 0;
    localparam int FULL_ST       = 33;
    localparam int MARK_POS      = 60;
    localparam int ADDR_MSB      = 61;
    localparam int MAP_FIRST_POS = 56;
    localparam int GROUP_MSB     = 53;
    localparam int REPLACE_POS   = 59;

    // Full-width pair row addresses
    localparam logic [2:0] FULL_ROW_A = 3'h6;
    localparam logic [2:0] FULL_ROW_B = 3'h7;

    // Reset values
    localparam logic [6:0] MAP_RESET = 7'h00;

    // One match row as held in flip-flops
    typedef struct packed {
        logic [FULL_W-1:0]  vec_a;
        logic [FULL_W-1:0]  vec_b;
        logic [STATE_W-1:0] st_a;
        logic [STATE_W-1:0] st_b;
        logic               mark;
        logic               replace;
        logic [GROUP_W-1:0] group;
    } row_t;

    // Machine state bits that qualify a match
    typedef struct packed {
        logic problem_state_bit;
        logic float_available_bit;
        logic vector_available_bit;
    } mstate_t;

endpackage : match_cam_pkg

// ==== rtl/instruction_match_cam.sv ====
`timescale 1ns/1ps
// Operation
// - Eight rows; rows 0-5 compare 17 opcode and extended opcode bits.
// - Rows 6 and 7 together form one full 32-bit comparator.
// - The mark bit at 60 of rows 0-5 and 7 sets the predecode tag; row 6's mark is ignored.
// - Rows qualify on problem state, float available and vector available bits.
// - Grouping replacement at 53:58 and enable at 59, hidden from software.
// - Each vector bit pair decodes to one of four criteria.
// - 00 never, 01 matches one, 10 matches zero, 11 always.
// - Short vector bits 0-5 hit instruction 0-5, 6-16 hit 21-31.
// - Short rows can match branches, as can the full pair; no row looks at the branch bit.
// - One write fills a short row with both vectors, states, mark, address.
// - Read returns reservation map, bits 56-62 for rows 0-6.
// - Writes to a reserved row are ignored.
// - Map shows debug reservations only; vectors cannot be read back.
// - Map readable in supervisor and user mode.
// - Row writes are honoured only in supervisor mode.
// - Mark persists until cleared, rewritten, rebooted or overwritten by service port.
// - Mark row and reserved row both matching apply both treatments.
// - Reserved and hidden positions ignore writes; reads show only map bits 56-62, all else zero.
// - Mark bit goes out with branch, first, split, last predecode bits.
// - Reserved force-alone row match sets first and last predecode bits unless a higher-numbered replacing row also matches.
module instruction_match_cam (
    // Clock and reset
    input  wire logic                        CLOCK,
    input  wire logic                        NRST,
    // Software register moves
    input  wire logic                        WR_EN,
    input  wire logic [63:0]                 WR_DATA,
    input  wire logic                        SUPERVISOR,
    input  wire logic                        RD_EN,
    output logic      [63:0]                 RD_DATA,
    // Service port row load and reservation
    input  wire logic                        SVC_WR_EN,
    input  wire logic [2:0]                  SVC_ROW,
    input  wire match_cam_pkg::row_t         SVC_ROW_DATA,
    input  wire logic                        SVC_RESERVE,
    // Fetched instruction in
    input  wire logic                        FETCH_VALID,
    input  wire logic [31:0]                 FETCH_INSTR,
    input  wire match_cam_pkg::mstate_t      FETCH_STATE,
    input  wire logic [3:0]                  FETCH_PREDECODE,
    // Tagged instruction out toward the cache
    output logic                             TAG_VALID,
    output logic [31:0]                      TAG_INSTR,
    output logic [3:0]                       TAG_PREDECODE,
    output logic                             TAG_MARK
);

    localparam int RW = match_cam_pkg::ROWS;

    // Little-endian slice bases of the write image; the image counts bit 0 as its MSB,
    // so each base is the top index minus the position of the field's last bit
    localparam int W_TOP    = 63;
    localparam int SA_BASE  = W_TOP - (match_cam_pkg::SHORT_A_MSB + match_cam_pkg::SHORT_W - 1);
    localparam int SAS_BASE = W_TOP - (match_cam_pkg::SHORT_A_ST + match_cam_pkg::STATE_W - 1);
    localparam int SB_BASE  = W_TOP - (match_cam_pkg::SHORT_B_MSB + match_cam_pkg::SHORT_W - 1);
    localparam int SBS_BASE = W_TOP - (match_cam_pkg::SHORT_B_ST + match_cam_pkg::STATE_W - 1);
    localparam int FV_BASE  = W_TOP - (match_cam_pkg::FULL_V_MSB + match_cam_pkg::FULL_W - 1);
    localparam int FS_BASE  = W_TOP - (match_cam_pkg::FULL_ST + match_cam_pkg::STATE_W - 1);
    localparam int AD_BASE  = W_TOP - (match_cam_pkg::ADDR_MSB + 2);
    localparam int MK_BIT   = W_TOP - match_cam_pkg::MARK_POS;

    // Row store and reservation map
    match_cam_pkg::row_t  rows_reg  [RW];
    match_cam_pkg::row_t  rows_next [RW];
    logic [6:0]           map_reg;
    logic [6:0]           map_next;
    // Read data
    logic [63:0]          rd_reg;
    logic [63:0]          rd_next;
    // Tag slot
    logic                 tv_reg;
    logic                 tv_next;
    logic [31:0]          ti_reg;
    logic [31:0]          ti_next;
    logic [3:0]           tp_reg;
    logic [3:0]           tp_next;
    logic                 tm_reg;
    logic                 tm_next;
    // Per-row compare result and reservation
    logic [RW-1:0]        hit;
    logic [RW-1:0]        held;

    // Reservation map widened to one bit a row; the pair's second half is never
    // reserved, so its bit is a constant zero rather than an out-of-range read
    assign held = {1'b0, map_reg};

    ////////////////////////////////////////////////////////////////////////////
    // Compare helper: one vector bit pair against one instruction bit
    // A 00 pair disables the whole row, which is how an unused row is switched off
    // two-bit criterion
    function automatic logic crit(input logic a, input logic b, input logic x);
        case ({a, b})
            2'h0:    crit = 1'b0;
            2'h1:    crit = x;
            2'h2:    crit = ~x;
            default: crit = 1'b1;
        endcase
    endfunction : crit

    // Fields are numbered from the MSB, so convert to a little-endian index
    // Only used with constant arguments, so it costs no logic
    function automatic int lsb(input int pos);
        lsb = 63 - pos;
    endfunction : lsb

    ////////////////////////////////////////////////////////////////////////////
    // Match compare, fully combinational off the fetch port
    // Kept combinational so the tag leaves one cycle after the fetch; the price is
    // a deep AND tree per row, which is the critical path of the block
    // Row contents written at an edge take part in the compare from that edge on
    always_comb begin
        logic [16:0] sbits;
        logic        ok;
        logic [2:0]  st;
        sbits = 17'h00000;
        ok    = 1'b0;
        st    = FETCH_STATE;
        hit   = '0;
        // Instruction bit 0 sits at FETCH_INSTR[31]; vector bit 16 is instruction bit 0
        // short row bit mapping
        sbits = {FETCH_INSTR[31:26], FETCH_INSTR[10:0]};
        for (int r = 0; r < match_cam_pkg::SHORT_ROWS; r++) begin
            ok = 1'b1;
            for (int n = 0; n < match_cam_pkg::SHORT_W; n++) begin
                ok = ok & crit(rows_reg[r].vec_a[n], rows_reg[r].vec_b[n], sbits[n]);
            end
            for (int n = 0; n < match_cam_pkg::STATE_W; n++) begin
                ok = ok & crit(rows_reg[r].st_a[n], rows_reg[r].st_b[n], st[n]);
            end
            hit[r] = ok;
        end
        // Each pair write lands in vec_a of its own row, so row 7's vec_a is vector b
        // Until both halves are written the zero half disables the pair, unless the written half is all ones
        // row 6 holds vector a, row 7 vector b
        ok = 1'b1;
        for (int n = 0; n < match_cam_pkg::FULL_W; n++) begin
            ok = ok & crit(rows_reg[6].vec_a[n], rows_reg[7].vec_a[n], FETCH_INSTR[n]);
        end
        for (int n = 0; n < match_cam_pkg::STATE_W; n++) begin
            ok = ok & crit(rows_reg[6].st_a[n], rows_reg[7].st_a[n], st[n]);
        end
        // Pair acts as one row; row 7 carries the mark written last
        hit[6] = ok;
        hit[7] = ok;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Tagging of the fetched instruction
    // Rows are visited in index order: a replacement rewrites the low predecode bits,
    // and a later force-alone row sets first and last on top of it
    // The mark of row 6 is skipped, since the pair's mark lives in row 7
    always_comb begin
        logic [3:0] pd;
        logic       mk;
        pd = FETCH_PREDECODE;
        mk = 1'b0;
        for (int r = 0; r < RW; r++) begin
            if (hit[r]) begin
                if (r != 6) begin
                    mk = mk | rows_reg[r].mark;
                end
                if (rows_reg[r].replace) begin
                    pd = {pd[3], rows_reg[r].group[2:0]};
                end
                if (held[r]) begin
                    pd[1] = 1'b1;
                    pd[0] = 1'b1;
                end
            end
        end
        // Predecode travels as {branch, split, first, last}
        // mark travels with predecode
        tv_next = FETCH_VALID;
        ti_next = FETCH_INSTR;
        tp_next = pd;
        tm_next = FETCH_VALID & mk;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Row writes, service overwrite and map read
    // Software may only touch vectors, state bits and the mark; replacement fields
    // and the reservation map stay with the service port
    // Limitation: a service load and a software write to one row in one cycle
    // keep only the service image
    always_comb begin
        logic [2:0] a;
        logic       ok;
        a  = WR_DATA[AD_BASE +: 3];
        ok = 1'b0;
        for (int r = 0; r < RW; r++) begin
            rows_next[r] = rows_reg[r];
        end
        map_next = map_reg;
        rd_next  = rd_reg;
        // supervisor only
        // Row 7 reads as unreserved, so the pair can always be completed
        // reserved rows are no-op
        ok = WR_EN && SUPERVISOR && !held[a];
        if (ok) begin
            if (a < match_cam_pkg::FULL_ROW_A) begin
                rows_next[a].vec_a[16:0] = WR_DATA[SA_BASE +: 17];
                rows_next[a].st_a        = WR_DATA[SAS_BASE +: 3];
                rows_next[a].vec_b[16:0] = WR_DATA[SB_BASE +: 17];
                rows_next[a].st_b        = WR_DATA[SBS_BASE +: 3];
            end else begin
                rows_next[a].vec_a = WR_DATA[FV_BASE +: 32];
                rows_next[a].st_a  = WR_DATA[FS_BASE +: 3];
            end
            rows_next[a].mark = WR_DATA[MK_BIT];
        end
        // Service port wins over software, as scan would
        // A service load also sets or clears the row's reservation in one step
        if (SVC_WR_EN) begin
            rows_next[SVC_ROW] = SVC_ROW_DATA;
            if (SVC_ROW != 3'h7) begin
                map_next[SVC_ROW] = SVC_RESERVE;
            end
        end
        // Read strobe is not qualified by the mode; bits outside the map read as zero,
        // so no row content ever leaves through the read path
        // any mode may read
        if (RD_EN) begin
            rd_next = 64'h0000000000000000;
            for (int r = 0; r < 7; r++) begin
                rd_next[lsb(match_cam_pkg::MAP_FIRST_POS + r)] = map_reg[r];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Row store and map; a reboot clears rows, marks and map
    // Reservations are lost on reboot until the service port loads them again
    always_ff @(posedge CLOCK) begin
        if (!NRST) begin
            for (int r = 0; r < RW; r++) begin
                rows_reg[r] <= '0;
            end
            map_reg <= match_cam_pkg::MAP_RESET;
        end else begin
            for (int r = 0; r < RW; r++) begin
                rows_reg[r] <= rows_next[r];
            end
            map_reg <= map_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data register, held until the next read
    always_ff @(posedge CLOCK) begin
        if (!NRST) begin
            rd_reg <= 64'h0000000000000000;
        end else begin
            rd_reg <= rd_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Tag slot, refreshed every cycle from the fetch port
    always_ff @(posedge CLOCK) begin
        if (!NRST) begin
            tv_reg <= 1'b0;
            ti_reg <= 32'h00000000;
            tp_reg <= 4'h0;
            tm_reg <= 1'b0;
        end else begin
            tv_reg <= tv_next;
            ti_reg <= ti_next;
            tp_reg <= tp_next;
            tm_reg <= tm_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs straight from flip-flops; no logic after the registers

    assign RD_DATA       = rd_reg;
    assign TAG_VALID     = tv_reg;
    assign TAG_INSTR     = ti_reg;
    assign TAG_PREDECODE = tp_reg;
    assign TAG_MARK      = tm_reg;

endmodule : instruction_match_cam

// ==== test/match_props.sv ====
`timescale 1ns/1ps
module match_props (
    // Clock and reset
    input wire logic        CLOCK,
    input wire logic        NRST,
    // Register and service side
    input wire logic        RD_EN,
    input wire logic [63:0] RD_DATA,
    input wire logic        SVC_WR_EN,
    input wire logic        SVC_RESERVE,
    input wire logic [2:0]  SVC_ROW,
    // Fetch and tag side
    input wire logic        FETCH_VALID,
    input wire logic [31:0] FETCH_INSTR,
    input wire logic [3:0]  FETCH_PREDECODE,
    input wire logic        TAG_VALID,
    input wire logic [31:0] TAG_INSTR,
    input wire logic [3:0]  TAG_PREDECODE,
    input wire logic        TAG_MARK
);
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!NRST);
    // Tag slot mirrors the fetch slot a cycle later, branch bit never rewritten
    a_tag_follow:
        assert property (FETCH_VALID |=> TAG_VALID && TAG_INSTR == $past(FETCH_INSTR))
        else $error("tag word lost");
    a_tag_idle:
        assert property (!FETCH_VALID |=> !TAG_VALID) else $error("tag without fetch");
    a_branch_kept:
        assert property (FETCH_VALID |=> TAG_PREDECODE[3] == $past(FETCH_PREDECODE[3]))
        else $error("branch bit changed");
    // Map reads show reservations only, nothing else leaks out
    a_map_spare:
        assert property (RD_EN |=> RD_DATA[63:8] == 56'h0 && !RD_DATA[0])
        else $error("spare map bits set");
    a_map_hold:
        assert property (!RD_EN |=> $stable(RD_DATA)) else $error("read data moved");
    a_map_set:
        assert property (SVC_WR_EN && SVC_RESERVE && SVC_ROW == 3'h1 ##2 RD_EN |=> RD_DATA[6])
        else $error("reservation not shown");
    a_map_sticky:
        assert property (RD_EN && RD_DATA[6] |=> RD_DATA[6]) else $error("reservation lost");
    // Reset leaves no mark and an empty map behind
    a_reset_clear:
        assert property ($rose(NRST) |-> !TAG_VALID && !TAG_MARK && RD_DATA == 64'h0)
        else $error("state survived reset");
endmodule : match_props
bind instruction_match_cam match_props match_props_i (.CLOCK(CLOCK), .NRST(NRST),
    .RD_EN(RD_EN), .RD_DATA(RD_DATA), .SVC_WR_EN(SVC_WR_EN), .SVC_RESERVE(SVC_RESERVE),
    .SVC_ROW(SVC_ROW), .FETCH_VALID(FETCH_VALID), .FETCH_INSTR(FETCH_INSTR),
    .FETCH_PREDECODE(FETCH_PREDECODE), .TAG_VALID(TAG_VALID), .TAG_INSTR(TAG_INSTR),
    .TAG_PREDECODE(TAG_PREDECODE), .TAG_MARK(TAG_MARK));

// ==== test/fetch_path_model.sv ====
`timescale 1ns/1ps
module fetch_path_model (
    // Requests from the bench
    input  wire logic                   clock,
    input  wire logic                   go,
    input  wire logic [31:0]            instr,
    input  wire match_cam_pkg::mstate_t st,
    input  wire logic [3:0]             pred,
    // Fetch side of the array
    output logic                        valid,
    output logic [31:0]                 f_instr,
    output match_cam_pkg::mstate_t      f_state,
    output logic [3:0]                  f_pred
);
    logic [31:0] last_reg = 32'h0;
    // Idle slot shows the inverse of the last word, so stale data never looks fresh
    always_ff @(posedge clock) begin
        if (go) begin
            last_reg <= instr;
        end
    end
    // no word is cached here, so every fetch sees the rows as written now
    assign valid   = go;
    assign f_instr = go ? instr : ~last_reg;
    assign f_state = st;
    assign f_pred  = go ? pred : ~pred;
endmodule : fetch_path_model

// ==== test/instruction_match_cam_tb.sv ====
`timescale 1ns/1ps
module instruction_match_cam_tb;
    logic CLOCK = 1'b0, NRST = 1'b0, WR_EN = 1'b0, SUPERVISOR = 1'b1, RD_EN = 1'b0;
    logic SVC_WR_EN = 1'b0, SVC_RESERVE = 1'b0, go = 1'b0, FETCH_VALID, TAG_VALID, TAG_MARK;
    logic [63:0] WR_DATA = 64'h0, RD_DATA;
    logic [31:0] ins = 32'h0, FETCH_INSTR, TAG_INSTR, seed = 32'h1a28, va[8], vb[8], t, d, j;
    logic [3:0]  pred = 4'h0, FETCH_PREDECODE, TAG_PREDECODE;
    logic [2:0]  SVC_ROW = 3'h0, sa[8], sb[8];
    logic [7:0]  mk, res;
    logic [6:0]  rp[8];
    match_cam_pkg::row_t    SVC_ROW_DATA = '0;
    match_cam_pkg::mstate_t st = '0, FETCH_STATE;
    int error_cnt = 0;
    int n_checks = 0;
    // 40 MHz clock
    initial forever #12.5 CLOCK = ~CLOCK;
    instruction_match_cam instruction_match_cam_i (.CLOCK(CLOCK), .NRST(NRST), .WR_EN(WR_EN),
        .WR_DATA(WR_DATA), .SUPERVISOR(SUPERVISOR), .RD_EN(RD_EN), .RD_DATA(RD_DATA),
        .SVC_WR_EN(SVC_WR_EN), .SVC_ROW(SVC_ROW), .SVC_ROW_DATA(SVC_ROW_DATA),
        .SVC_RESERVE(SVC_RESERVE), .FETCH_VALID(FETCH_VALID), .FETCH_INSTR(FETCH_INSTR),
        .FETCH_STATE(FETCH_STATE), .FETCH_PREDECODE(FETCH_PREDECODE), .TAG_VALID(TAG_VALID),
        .TAG_INSTR(TAG_INSTR), .TAG_PREDECODE(TAG_PREDECODE), .TAG_MARK(TAG_MARK));
    fetch_path_model fetch_path_model_i (.clock(CLOCK), .go(go), .instr(ins), .st(st),
        .pred(pred), .valid(FETCH_VALID), .f_instr(FETCH_INSTR), .f_state(FETCH_STATE),
        .f_pred(FETCH_PREDECODE));
    ////////////////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    // per bit: a one takes the b vector, a zero the a vector
    function automatic logic hit(logic [31:0] x, a, b, logic [2:0] s, p, q);
        return &((x & b) | (~x & a)) && &((s & q) | (~s & p));
    endfunction : hit
    // Expected {mark, predecode}; upper bits of short rows are forced to don't care
    function automatic logic [4:0] want(logic [31:0] x, logic [2:0] s, logic [3:0] p);
        logic m;
        m = hit(x, va[6], vb[7], s, sa[6], sb[7]) & mk[7];
        for (int r = 0; r < 6; r++) begin
            if (hit({x[31:26], x[10:0]}, va[r] | 32'hfffe0000, vb[r] | 32'hfffe0000,
                    s, sa[r], sb[r])) begin
                m |= mk[r];
                // Row by row: replacement of the low bits, then force-alone on top
                if (rp[r][6]) p = {p[3], rp[r][2:0]};
                if (res[r]) p[1:0] = 2'h3;
            end
        end
        return {m, p};
    endfunction : want
    // Write image aimed at word t, don't-care bits d, hidden fields filled with noise
    function automatic logic [63:0] img(logic [31:0] t, d, logic [2:0] s, c, r, logic m);
        logic [16:0] k, e;
        k = {t[31:26], t[10:0]};
        e = {d[31:26], d[10:0]};
        if (r < 6) return {~k | e, 1'b0, ~s | c, k | e, 1'b0, s | c, seed[17:0], m, r};
        return {(r[0] ? t : ~t) | d, 1'b0, (r[0] ? s : ~s) | c, seed[23:0], m, r};
    endfunction : img
    ////////////////////////////////////////////////////////////////////////////////////////////
    task automatic check(string name, logic [63:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic stop_test();
        if (error_cnt == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : stop_test
    task automatic rst();
        NRST = 1'b0;
        repeat (2) @(posedge CLOCK);
        #1 NRST = 1'b1;
        {mk, res} = 16'h0;
        for (int r = 0; r < 8; r++) begin
            {va[r], vb[r], sa[r], sb[r]} = 70'h0;
            rp[r] = 7'h0;
        end
    endtask : rst
    // Write lands in the bench copy only when allowed
    task automatic wr(logic [63:0] w);
        int r;
        r = w[2:0];
        @(posedge CLOCK) #1 WR_EN = 1'b1;
        WR_DATA = w;
        @(posedge CLOCK) #1 WR_EN = 1'b0;
        if (SUPERVISOR && !res[r]) begin
            if (r < 6) {va[r], sa[r], vb[r], sb[r]} = {15'h0, w[63:47], w[45:43], 15'h0,
                                                      w[42:26], w[24:22]};
            else if (r == 6) {va[6], sa[6]} = {w[63:32], w[30:28]};
            else {vb[7], sb[7]} = {w[63:32], w[30:28]};
            mk[r] = w[3];
        end
    endtask : wr
    task automatic rd();
        logic [63:0] e;
        @(posedge CLOCK) #1 RD_EN = 1'b1;
        @(posedge CLOCK) #1 RD_EN = 1'b0;
        e = 64'h0;
        for (int r = 0; r < 7; r++) e[7 - r] = res[r];
        check("map", RD_DATA, e);
    endtask : rd
    // Service port loads a short row aimed at word w, reserved if rv, replacement g
    task automatic svc(logic [2:0] r, logic [31:0] w, logic rv, logic [6:0] g);
        @(posedge CLOCK) #1 SVC_WR_EN = 1'b1;
        SVC_ROW = r;
        SVC_RESERVE = rv;
        va[r] = {15'h0, ~w[31:26], ~w[10:0]};
        vb[r] = {15'h0, w[31:26], w[10:0]};
        {sa[r], sb[r], mk[r], res[r]} = {7'h7e, rv};
        rp[r] = g;
        SVC_ROW_DATA = '{vec_a: va[r], vec_b: vb[r], st_a: 3'h7, st_b: 3'h7, mark: 1'b0,
                         replace: g[6], group: g[5:0]};
        @(posedge CLOCK) #1 SVC_WR_EN = 1'b0;
    endtask : svc
    task automatic fetch(logic [31:0] x, logic [2:0] s);
        logic [4:0] e;
        @(posedge CLOCK) #1 go = 1'b1;
        ins = x;
        st = s;
        pred = 4'(rnd() >> 9);
        e = want(x, s, pred);
        @(posedge CLOCK) #1 go = 1'b0;
        check("mark", TAG_MARK, e[4]);
        check("predecode", TAG_PREDECODE, e[3:0]);
    endtask : fetch
    ////////////////////////////////////////////////////////////////////////////////////////////
    // Sequence: empty map in both modes, twin rows (one reserved, one replacing), random rows, closing reset then one read and one fetch
    initial begin
        rst();
        rd();
        SUPERVISOR = 1'b0;
        rd();
        SUPERVISOR = 1'b1;
        svc(3'h1, 32'h7c0002a6, 1'b1, 7'h00);
        rd();
        svc(3'h2, 32'h7c0002a6, 1'b0, 7'h45);
        rd();
        wr(img(32'h7c0002a6, 32'h0, 3'h5, 3'h7, 3'h0, 1'b1));
        fetch(32'h7c0002a6, 3'h5);
        for (int i = 0; i < 60; i++) begin
            t = rnd();
            d = rnd() & rnd() & rnd();
            j = rnd();
            SUPERVISOR = j[6:3] != 4'h0;
            if (j[2:0] < 3'h6) wr(img(t, d, j[9:7], j[12:10] & j[15:13], j[2:0], j[16]));
            else begin
                wr(img(t, d, j[9:7], j[12:10] & j[15:13], 3'h6, 1'b0));
                wr(img(t, d, j[9:7], j[12:10] & j[15:13], 3'h7, j[16]));
            end
            fetch(t, j[9:7]);
            fetch(t ^ (32'h1 << j[21:17]), j[9:7]);
            fetch(t, ~j[9:7]);
            fetch(32'h7c0002a6, j[24:22]);
        end
        rd();
        rst();
        rd();
        fetch(t, j[9:7]);
        stop_test();
    end
    // Watchdog well beyond the expected run
    initial begin
        #100us;
        error_cnt++;
        stop_test();
    end
endmodule : instruction_match_cam_tb
